// ### inc/cssc_params.svh
`ifndef CSSC_PARAMS_SVH
`define CSSC_PARAMS_SVH
// ****************************************
// Register byte offsets.
// ****************************************
`define CSSC_ADDR_CFG 8'h00
`define CSSC_ADDR_DUTY0 8'h04
`define CSSC_ADDR_DUTY1 8'h08
`define CSSC_ADDR_OCP 8'h0C
`define CSSC_ADDR_STAT 8'h10
`define CSSC_ADDR_SENSE 8'h14
// ****************************************
// Field positions and reset values.
// ****************************************
`define CSSC_CFG_SEL_LO 0
`define CSSC_CFG_SEL_HI 1
`define CSSC_CFG_TH 2
`define CSSC_CFG_MODE0 3
`define CSSC_CFG_MODE1 5
`define CSSC_CFG_RST 7'h00
`define CSSC_OCP_RST 32'h00804010
`define CSSC_STAT_FCLR 2
// ****************************************
// Timing.
// ****************************************
`define CSSC_CLK_NS 10
`define CSSC_SETTLE_NS 2000
`define CSSC_SETTLE_CYC ((`CSSC_SETTLE_NS + `CSSC_CLK_NS - 1) / `CSSC_CLK_NS)
`define CSSC_PWM_DIV 390
`define CSSC_STAGES 4
`define CSSC_RST_LOW_US 10
`endif

// ### inc/cssc_pkg.sv
// Shared types of the sense control block.
package cssc_pkg;
   // Switching mode of one channel.
   typedef enum logic [1:0] {
      CSSC_MODE_INT,
      CSSC_MODE_EXT,
      CSSC_MODE_DIRECT,
      CSSC_MODE_SPARE
   } cssc_mode_e;
   // Sense function chosen by the two select bits {hi, lo}.
   typedef enum logic [1:0] {
      CSSC_SEL_OFF,
      CSSC_SEL_CH0,
      CSSC_SEL_CH1,
      CSSC_SEL_TEMP
   } cssc_sel_e;
endpackage : cssc_pkg

// ### src/cssc_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "cssc_params.svh"
module cssc_channel
   import cssc_pkg::*;
#(
   parameter int W = 8,
   parameter int DIV = `CSSC_PWM_DIV,
   parameter int STAGES = `CSSC_STAGES
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire cssc_mode_e mode,
   input wire logic [7:0] duty,
   input wire logic [7:0] height,
   input wire logic [7:0] width,
   input wire logic [7:0] steady,
   input wire logic motor,
   input wire logic direct_in,
   input wire logic ext_clock,
   input wire logic [W-1:0] current,
   input wire logic fault_clr,
   output logic on,
   output logic off_pulse,
   output logic oc_window,
   output logic fault,
   output logic [W-1:0] held
);
   typedef struct packed {
      logic [15:0] pre;
      logic [7:0] pwm;
      logic ext_d;
      logic [7:0] wcnt;
      logic [2:0] stage;
      logic on;
      logic off_pulse;
      logic fault;
      logic [W-1:0] held;
   } cssc_ch_s;
   cssc_ch_s s, n;
   logic tick, demand, window, trip;
   logic [2:0] rem;
   logic [11:0] thr;

   // ****************************************
   // Switching, overcurrent profile and hold.
   // ****************************************
   // One next-state process covers the whole channel.
   always_comb begin
      n = s;
      n.ext_d = ext_clock;
      demand = direct_in;
      tick = 1'b0;
      unique case (mode)
         CSSC_MODE_INT: begin
            tick = (s.pre == 16'(DIV - 1));
            demand = (s.pwm < duty);
         end
         CSSC_MODE_EXT: begin
            tick = ext_clock & ~s.ext_d;
            demand = (s.pwm < duty);
         end
         default: demand = direct_in;
      endcase
      n.pre = (mode == CSSC_MODE_INT && !tick) ? s.pre + 16'h0001 : 16'h0000;
      if (tick) begin
         n.pwm = s.pwm + 8'h01;
      end
      // Bulbs step down the threshold, motors get a flat stall window.
      window = s.on && (s.stage < 3'(STAGES));
      rem = window ? (motor ? 3'(STAGES) : 3'(STAGES) - s.stage) : 3'h0;
      thr = 12'(steady) + 12'(height) * 12'(rem);
      trip = s.on && (12'(current) > thr);
      n.fault = trip | (s.fault & ~fault_clr);
      n.on = demand & ~n.fault;
      n.off_pulse = s.on & ~n.on;
      if (!s.on) begin
         n.stage = 3'h0;
         n.wcnt = 8'h00;
      end else if (window) begin
         if (s.wcnt >= width - 8'h01) begin
            n.wcnt = 8'h00;
            n.stage = s.stage + 3'h1;
         end else begin
            n.wcnt = s.wcnt + 8'h01;
         end
      end
      // The last on-state sample is what track-and-hold shows.
      if (s.on) begin
         n.held = current;
      end
   end

   // State register.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign on = s.on;
   assign off_pulse = s.off_pulse;
   assign oc_window = window;
   assign fault = s.fault;
   assign held = s.held;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   direct_follow_a: assert property (mode == CSSC_MODE_DIRECT && direct_in && !n.fault
      |=> on) else $error("direct input did not switch channel on");
   trip_off_a: assert property (trip |=> (!on && fault) [*2])
      else $error("overcurrent did not latch channel off");
   hold_value_a: assert property ($fell(on) |-> held == $past(current) && off_pulse)
      else $error("held value or off pulse wrong at turn-off");
endmodule : cssc_channel
`default_nettype wire

// ### src/cssc_top.sv
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cssc_params.svh"
// Behaviour
// - The two select bits choose channel 0, channel 1 or temperature sensing.
// - Both select bits zero tri-states the sense output; host zeroes unused devices.
// - Track-and-hold shows the load current captured just before turn-off.
// - Sense output is disabled while the monitored channel has an overcurrent window.
// - No sensing in fail-safe mode or without interface supply.
// - Ready is pulled low once the sense value is valid, held while valid.
// - Ready is released at every turn-off of the monitored channel.
// - Each channel runs internal PWM, external-clock PWM or direct input control.
// - Bulbs get a stepped overcurrent threshold, motors a stall-current window.
module cssc_top
   import cssc_pkg::*;
#(
   parameter int W = 8,
   parameter int SETTLE = `CSSC_SETTLE_CYC
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [1:0] direct_in,
   input wire logic ext_clock,
   input wire logic [1:0] load_motor,
   input wire logic fail_safe,
   input wire logic vdd_present,
   input wire logic [1:0][W-1:0] load_current,
   input wire logic [W-1:0] temp_value,
   output logic [W-1:0] sense_output,
   output logic sense_oe_n,
   input wire logic ready_in,
   output logic ready_out,
   output logic ready_oe_n,
   output logic [1:0] channel_on,
   output logic [1:0] channel_fault
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [6:0] cfg;
      logic [7:0] duty0;
      logic [7:0] duty1;
      logic [31:0] ocp;
      logic [1:0] fclr;
      logic [W-1:0] sense;
      logic sense_oe_n;
      logic ready_oe_n;
      logic [15:0] settle;
      logic [1:0] sel_d;
   } cssc_top_s;
   cssc_top_s s, n;
   logic [1:0] on, off_p, ocw, flt;
   logic [1:0][W-1:0] held;
   logic [31:0] wmerged, stat;
   cssc_sel_e sel;
   logic en, off_evt;
   logic [W-1:0] val;
   cssc_mode_e mode [2];

   // Byte-lane merge of a write into a register's old value.
   function automatic logic [31:0] cssc_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction : cssc_merge

   // ****************************************
   // Channels.
   // ****************************************
   assign mode[0] = cssc_mode_e'(s.cfg[`CSSC_CFG_MODE0 +: 2]);
   assign mode[1] = cssc_mode_e'(s.cfg[`CSSC_CFG_MODE1 +: 2]);

   // Both channels share the profile settings but switch on their own.
   for (genvar c = 0; c < 2; c++) begin : g_ch
      cssc_channel #(.W(W)) u_cssc_channel (
         .sys_clk(sys_clk),
         .nrst(nrst),
         .mode(mode[c]),
         .duty(c == 0 ? s.duty0 : s.duty1),
         .height(s.ocp[7:0]),
         .width(s.ocp[15:8]),
         .steady(s.ocp[23:16]),
         .motor(load_motor[c]),
         .direct_in(direct_in[c]),
         .ext_clock(ext_clock),
         .current(load_current[c]),
         .fault_clr(s.fclr[c]),
         .on(on[c]),
         .off_pulse(off_p[c]),
         .oc_window(ocw[c]),
         .fault(flt[c]),
         .held(held[c])
      );
   end

   // ****************************************
   // Register bus and sense control.
   // ****************************************
   assign stat = {24'h000000, ~s.sense_oe_n, ~ready_in, ocw, flt, on};
   assign sel = cssc_sel_e'({s.cfg[`CSSC_CFG_SEL_HI], s.cfg[`CSSC_CFG_SEL_LO]});

   // Next state of the slave, the registers and the sense path.
   always_comb begin
      n = s;
      n.fclr = 2'h0;
      wmerged = 32'h00000000;
      // Write address and data are taken in either order.
      if (awvalid && s.awready) begin
         n.awready = 1'b0;
         n.aw_held = 1'b1;
         n.awaddr = awaddr;
      end
      if (wvalid && s.wready) begin
         n.wready = 1'b0;
         n.w_held = 1'b1;
         n.wdata = wdata;
         n.wstrb = wstrb;
      end
      if (s.aw_held && s.w_held) begin
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = 2'b00;
         unique case (s.awaddr)
            `CSSC_ADDR_CFG: begin
               wmerged = cssc_merge({25'h0000000, s.cfg}, s.wdata, s.wstrb);
               n.cfg = wmerged[6:0];
            end
            `CSSC_ADDR_DUTY0: begin
               wmerged = cssc_merge({24'h000000, s.duty0}, s.wdata, s.wstrb);
               n.duty0 = wmerged[7:0];
            end
            `CSSC_ADDR_DUTY1: begin
               wmerged = cssc_merge({24'h000000, s.duty1}, s.wdata, s.wstrb);
               n.duty1 = wmerged[7:0];
            end
            `CSSC_ADDR_OCP: n.ocp = cssc_merge(s.ocp, s.wdata, s.wstrb);
            `CSSC_ADDR_STAT: n.fclr = s.wdata[`CSSC_STAT_FCLR +: 2] & {2{s.wstrb[0]}};
            `CSSC_ADDR_SENSE: n.bresp = 2'b00;
            default: n.bresp = 2'b10;
         endcase
      end
      if (s.bvalid && bready) begin
         n.bvalid = 1'b0;
         n.awready = 1'b1;
         n.wready = 1'b1;
      end
      // Reads answer one cycle after the address is taken.
      if (arvalid && s.arready) begin
         n.arready = 1'b0;
         n.rvalid = 1'b1;
         n.rresp = 2'b00;
         unique case (araddr)
            `CSSC_ADDR_CFG: n.rdata = {25'h0000000, s.cfg};
            `CSSC_ADDR_DUTY0: n.rdata = {24'h000000, s.duty0};
            `CSSC_ADDR_DUTY1: n.rdata = {24'h000000, s.duty1};
            `CSSC_ADDR_OCP: n.rdata = s.ocp;
            `CSSC_ADDR_STAT: n.rdata = stat;
            `CSSC_ADDR_SENSE: n.rdata = 32'(s.sense);
            default: begin
               n.rdata = 32'h00000000;
               n.rresp = 2'b10;
            end
         endcase
      end
      if (s.rvalid && rready) begin
         n.rvalid = 1'b0;
         n.arready = 1'b1;
      end
      // Route the chosen function, or release the pin.
      en = 1'b0;
      val = temp_value;
      off_evt = 1'b0;
      unique case (sel)
         CSSC_SEL_OFF: en = 1'b0;
         CSSC_SEL_CH0: begin
            en = !ocw[0] && (on[0] || s.cfg[`CSSC_CFG_TH]);
            val = on[0] ? load_current[0] : held[0];
            off_evt = off_p[0];
         end
         CSSC_SEL_CH1: begin
            en = !ocw[1] && (on[1] || s.cfg[`CSSC_CFG_TH]);
            val = on[1] ? load_current[1] : held[1];
            off_evt = off_p[1];
         end
         CSSC_SEL_TEMP: en = 1'b1;
      endcase
      en = en && vdd_present && !fail_safe;
      n.sense = en ? val : '0;
      n.sense_oe_n = ~en;
      n.sel_d = sel;
      // Ready falls after the settle time and rises on a turn-off of the monitored channel.
      if (!en || off_evt || sel != cssc_sel_e'(s.sel_d)) begin
         n.settle = 16'h0000;
      end else if (s.settle < 16'(SETTLE)) begin
         n.settle = s.settle + 16'h0001;
      end
      n.ready_oe_n = (n.settle != 16'(SETTLE));
   end

   // State register; select bits come out of reset cleared.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.cfg <= `CSSC_CFG_RST;
         s.awready <= 1'b1;
         s.wready <= 1'b1;
         s.arready <= 1'b1;
         s.ocp <= `CSSC_OCP_RST;
         s.sense_oe_n <= 1'b1;
         s.ready_oe_n <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // Outputs come straight from state registers; ready_out is tied low.
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rresp = s.rresp;
   assign rdata = s.rdata;
   assign sense_output = s.sense;
   assign sense_oe_n = s.sense_oe_n;
   assign ready_oe_n = s.ready_oe_n;
   assign ready_out = 1'b0;
   assign channel_on = on;
   assign channel_fault = flt;

   // ****************************************
   // Checks.
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   temp_route_a: assert property (sel == CSSC_SEL_TEMP && vdd_present && !fail_safe
      |=> !sense_oe_n && sense_output == $past(temp_value)) else $error("temperature not routed");
   sel_off_a: assert property (sel == CSSC_SEL_OFF |=> sense_oe_n && ready_oe_n)
      else $error("sense output driven with select bits zero");
   hold_show_a: assert property (sel == CSSC_SEL_CH0 && s.cfg[`CSSC_CFG_TH] && $fell(on[0])
      && !ocw[0] && vdd_present && !fail_safe |=> sense_output == $past(held[0]))
      else $error("track-and-hold value not shown");
   oc_window_a: assert property (sel == CSSC_SEL_CH0 && ocw[0] |=> sense_oe_n)
      else $error("sense output active in overcurrent window");
   no_supply_a: assert property (fail_safe || !vdd_present |=> sense_oe_n && ready_oe_n)
      else $error("sensing active without supply or in fail-safe");
   ready_valid_a: assert property (!ready_oe_n |-> !sense_oe_n && s.settle == 16'(SETTLE))
      else $error("ready asserted before sense settled");
   turnoff_rel_a: assert property (sel == CSSC_SEL_CH1 && off_p[1] |=> ready_oe_n [*2])
      else $error("ready not released at turn-off");

   // Channel 0 turn-off releases ready just as channel 1 does.
   turnoff_rel0_a: assert property (sel == CSSC_SEL_CH0 && off_p[0]
      |=> ready_oe_n [*2]) else $error("ready not released at channel 0 turn-off");
   // A monitored channel that is on and out of its window shows its live load current.
   ch0_route_a: assert property (sel == CSSC_SEL_CH0 && on[0] && !ocw[0]
      && vdd_present && !fail_safe |=> !sense_oe_n && sense_output == $past(load_current[0]))
      else $error("channel 0 current not routed");
   // The same routing holds when channel 1 is selected.
   ch1_route_a: assert property (sel == CSSC_SEL_CH1 && on[1] && !ocw[1]
      && vdd_present && !fail_safe |=> !sense_oe_n && sense_output == $past(load_current[1]))
      else $error("channel 1 current not routed");
endmodule : cssc_top
`default_nettype wire

// ### bench/cssc_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host board wiring.
// ****************************************
// Resolves the shared sense and ready wires as the host sees them.
module cssc_mcu_model #(
   parameter int W = 8
) (
   input wire logic [W-1:0] sense_output,
   input wire logic sense_oe_n,
   input wire logic ready_out,
   input wire logic ready_oe_n,
   output logic [W-1:0] sense_line,
   output logic ready_line
);
   // The sense resistor pulls a released sense wire down to zero.
   assign sense_line = sense_oe_n ? {W{1'h0}} : sense_output;
   // The pull-up lifts the ready wire; this host enables sensing on this one device only.
   assign ready_line = ready_oe_n ? 1'h1 : ready_out;
endmodule : cssc_mcu_model
`default_nettype wire

// ### bench/current_sense_sync_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cssc_params.svh"
module current_sense_sync_control_tb;
   // ****************************************
   // Signals.
   // ****************************************
   logic sys_clk = 1'h0;
   logic nrst = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] direct_in = 2'h0, load_motor = 2'h0;
   logic ext_clock = 1'h0, fail_safe = 1'h0, vdd_present = 1'h1;
   logic [1:0][7:0] load_current = 16'h0;
   logic [7:0] temp_value = 8'h00;
   logic awready, wready, bvalid, arready, rvalid, sense_oe_n, ready_out, ready_oe_n, ready_line;
   logic [1:0] bresp, rresp, channel_on, channel_fault;
   logic [31:0] rdata, rd;
   logic [7:0] sense_output, sense_line;
   int mismatches = 0;
   int check_count = 0;
   cssc_top #(.W(8), .SETTLE(4)) u_cssc_top (
      .sys_clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .direct_in, .ext_clock, .load_motor, .fail_safe, .vdd_present,
      .load_current, .temp_value, .sense_output, .sense_oe_n, .ready_in(ready_line),
      .ready_out, .ready_oe_n, .channel_on, .channel_fault
   );
   cssc_mcu_model #(.W(8)) u_cssc_mcu_model (
      .sense_output, .sense_oe_n, .ready_out, .ready_oe_n, .sense_line, .ready_line
   );
   // Free-running 100 MHz clock.
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // ****************************************
   // Shared tasks.
   // ****************************************
   task automatic print_verdict;
      if (mismatches == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic lim(input int n, input int max);
      if (n >= max) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, n, max);
         print_verdict();
      end
   endtask : lim
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   // Write one word, holding each channel until it is taken.
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      n = 0;
      do begin
         @(posedge sys_clk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         n++;
      end while (bvalid !== 1'h1 && n < 50);
      lim(n, 50);
      bready <= 1'h0;
      chk(bresp, er);
   endtask : axw
   // Read one word into rd.
   task automatic axr(input logic [7:0] a, input logic [1:0] er);
      int n;
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      n = 0;
      do begin
         @(posedge sys_clk);
         if (arready === 1'h1) arvalid <= 1'h0;
         n++;
      end while (rvalid !== 1'h1 && n < 50);
      lim(n, 50);
      rready <= 1'h0;
      rd = rdata;
      chk(rresp, er);
   endtask : axr
   // ****************************************
   // Scenarios.
   // ****************************************
   task automatic t_reset;
      chk(sense_oe_n, 1'h1);
      chk(ready_line, 1'h1);
      chk({awready, wready, arready, bvalid, rvalid}, 5'h1C);
      axr(`CSSC_ADDR_CFG, 2'h0);
      chk(rd, 32'h0);
      axr(`CSSC_ADDR_OCP, 2'h0);
      chk(rd, `CSSC_OCP_RST);
      axr(8'h20, 2'h2);
      chk(rd, 32'h0);
      axw(8'h24, 32'h1, 2'h2);
   endtask : t_reset
   task automatic t_route;
      axw(`CSSC_ADDR_OCP, 32'h00800410, 2'h0);
      load_current <= {8'h32, 8'h21};
      temp_value <= 8'h47;
      axw(`CSSC_ADDR_CFG, 32'h51, 2'h0);
      direct_in <= 2'h3;
      cyc(3);
      chk(channel_on, 2'h3);
      chk(sense_oe_n, 1'h1);
      cyc(30);
      chk(sense_line, 8'h21);
      axw(`CSSC_ADDR_CFG, 32'h52, 2'h0);
      cyc(3);
      chk(sense_line, 8'h32);
      axw(`CSSC_ADDR_CFG, 32'h53, 2'h0);
      cyc(3);
      chk(sense_line, 8'h47);
      axw(`CSSC_ADDR_CFG, 32'h50, 2'h0);
      cyc(3);
      chk(sense_oe_n, 1'h1);
      chk(sense_line, 8'h00);
   endtask : t_route
   task automatic t_ready;
      int n;
      axw(`CSSC_ADDR_CFG, 32'h55, 2'h0);
      n = 0;
      while (ready_line !== 1'h0 && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      lim(n, 40);
      cyc(5);
      chk(ready_line, 1'h0);
      direct_in <= 2'h2;
      n = 0;
      while (channel_on[0] !== 1'h0 && n < 8) begin
         @(posedge sys_clk);
         n++;
      end
      lim(n, 8);
      cyc(1);
      chk(ready_line, 1'h1);
      load_current <= {8'h32, 8'h99};
      cyc(8);
      chk(sense_line, 8'h21);
      axw(`CSSC_ADDR_CFG, 32'h51, 2'h0);
      cyc(3);
      chk(sense_oe_n, 1'h1);
   endtask : t_ready
   task automatic t_failsafe;
      direct_in <= 2'h3;
      load_current <= {8'h32, 8'h21};
      axw(`CSSC_ADDR_CFG, 32'h52, 2'h0);
      cyc(30);
      chk(sense_oe_n, 1'h0);
      fail_safe <= 1'h1;
      cyc(3);
      chk(sense_oe_n, 1'h1);
      fail_safe <= 1'h0;
      vdd_present <= 1'h0;
      cyc(3);
      chk(sense_oe_n, 1'h1);
      vdd_present <= 1'h1;
      cyc(3);
      chk(sense_oe_n, 1'h0);
   endtask : t_failsafe
   task automatic t_pwm;
      int n;
      logic seen_on, seen_off;
      direct_in <= 2'h0;
      axw(`CSSC_ADDR_CFG, 32'h20, 2'h0);
      seen_on = 1'h0;
      repeat (900) begin
         @(posedge sys_clk);
         if (channel_on[0] !== 1'h0) seen_on = 1'h1;
      end
      chk(seen_on, 1'h0);
      axw(`CSSC_ADDR_DUTY0, 32'hFF, 2'h0);
      n = 0;
      while (channel_on[0] !== 1'h1 && n < 900) begin
         @(posedge sys_clk);
         n++;
      end
      lim(n, 900);
      axw(`CSSC_ADDR_DUTY1, 32'h01, 2'h0);
      seen_on = 1'h0;
      seen_off = 1'h0;
      repeat (64) begin
         @(posedge sys_clk);
         ext_clock <= ~ext_clock;
         if (channel_on[1] === 1'h1) seen_on = 1'h1;
         if (channel_on[1] === 1'h0) seen_off = 1'h1;
      end
      chk({seen_on, seen_off}, 2'h3);
   endtask : t_pwm
   task automatic t_ocp;
      int n;
      direct_in <= 2'h0;
      axw(`CSSC_ADDR_CFG, 32'h10, 2'h0);
      for (int m = 0; m < 2; m++) begin
         load_motor <= {1'h0, m[0]};
         load_current <= {8'h32, 8'hB8};
         cyc(2);
         direct_in <= 2'h1;
         cyc(4);
         chk(channel_fault[0], 1'h0);
         n = 0;
         while (channel_fault[0] !== 1'h1 && n < 60) begin
            @(posedge sys_clk);
            n++;
         end
         lim(n, 60);
         // A bulb trips once the first step drops below the load, a motor only after its window.
         chk(n, m[0] ? 32'h0000000F : 32'h00000003);
         cyc(2);
         chk(channel_on[0], 1'h0);
         direct_in <= 2'h0;
         load_current <= {8'h32, 8'h10};
         axw(`CSSC_ADDR_STAT, 32'h4, 2'h0);
         axr(`CSSC_ADDR_STAT, 2'h0);
         chk(rd[2], 1'h0);
      end
   endtask : t_ocp
   // A long reset pulse switches off a channel that software turned on.
   task automatic t_rstlow;
      int n;
      direct_in <= 2'h0;
      axw(`CSSC_ADDR_CFG, 32'h00, 2'h0);
      n = 0;
      while (channel_on[0] !== 1'h1 && n < 8) begin
         @(posedge sys_clk);
         n++;
      end
      lim(n, 8);
      nrst <= 1'h0;
      cyc(`CSSC_RST_LOW_US * 1000 / `CSSC_CLK_NS);
      chk(channel_on, 2'h0);
      nrst <= 1'h1;
      chk(sense_oe_n, 1'h1);
      axr(`CSSC_ADDR_CFG, 2'h0);
      chk(rd, 32'h0);
      axr(`CSSC_ADDR_DUTY0, 2'h0);
      chk(rd, 32'h0);
      cyc(3);
      chk(channel_on, 2'h0);
   endtask : t_rstlow
   // ****************************************
   // Main sequence.
   // ****************************************
   // Resets for 20 cycles, then runs every scenario.
   initial begin
      repeat (20) @(posedge sys_clk);
      nrst <= 1'h1;
      t_reset();
      t_route();
      t_ready();
      t_failsafe();
      t_pwm();
      t_ocp();
      t_rstlow();
      print_verdict();
   end
   // Cuts a hung run short.
   initial begin
      #1000000;
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
      print_verdict();
   end
endmodule : current_sense_sync_control_tb
`default_nettype wire
